/* File: rtl/tmz_pkg.sv */
// Notes on behaviour
// [RL1] Run enable set: timer counts; clear: counting stops, dividers held cleared.
// [RL2] Control main bit 5 reads the timer output level; writes to it ignored.
// [RL3] Wide select set gives a 16-bit counter, clear an 8-bit periodic one.
// [RL4] Output divider ratio divides match or rollover events by field plus one.
// [RL5] Clock source codes select medium, low, high oscillators, instruction clock; 110 reserved.
// [RL6] Source 111 selects logic cell one output; 001 inverted pin, 000 plain pin.
// [RL7] Unsynced select set counts every edge; clear aligns edges to instruction clock.
// [RL8] Input divider ratio divides the selected clock by two to the field value.
// [RL9] All control bits reset to zero; unimplemented bit 6 reads zero.
// [RL10] 8-bit mode: low byte matching period clears it, pulses output, reloads period.
// [RL11] 16-bit mode: low-byte read latches high byte; low-byte write loads buffered high.
// [RL12] Event flag sets every ratio-plus-one events: 8-bit match or 16-bit FFFFh rollover.
// [RL13] Writes to low byte or either control register clear both dividers.
package tmz_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] ADDR_CTRL_MAIN = 8'h00;
    localparam logic [7:0] ADDR_CLK_CFG = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

    // timer_control_main fields
    localparam int RUN_BIT = 7;
    localparam int OUT_LEVEL_BIT = 5;
    localparam int WIDE_BIT = 4;
    localparam int OUT_DIV_LSB = 0;
    localparam logic [7:0] CTRL_MAIN_WMASK = 8'h9F;

    // timer_clock_config fields
    localparam int SRC_LSB = 5;
    localparam int UNSYNC_BIT = 4;
    localparam int IN_DIV_LSB = 0;

    // interrupt status layout
    localparam int EVENT_FLAG_BIT = 0;

    // reset values
    localparam logic [7:0] CTRL_MAIN_RST = 8'h00;
    localparam logic [7:0] CLK_CFG_RST = 8'h00;
    localparam logic [7:0] COUNT_LOW_RST = 8'h00;
    localparam logic [7:0] HIGH_BUF_RST = 8'hFF;
    localparam logic [7:0] PERIOD_RST = 8'hFF;

    // clock source codes
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_PIN_INV = 3'h1;
    localparam logic [2:0] SRC_INSTR = 3'h2;
    localparam logic [2:0] SRC_HIGH_OSC = 3'h3;
    localparam logic [2:0] SRC_LOW_OSC = 3'h4;
    localparam logic [2:0] SRC_MEDIUM_OSC = 3'h5;
    localparam logic [2:0] SRC_RESERVED = 3'h6;
    localparam logic [2:0] SRC_LOGIC_CELL = 3'h7;

    // instruction clock is the system clock divided by this
    localparam int INSTR_DIV = 4;

endpackage

/* File: rtl/tmz_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tmz_tick_if;
    logic srcLevel;
    logic unsynced;
    logic instrStrobe;
    logic [3:0] ratio;
    logic clear;
    logic tick;

    modport core (output srcLevel, output unsynced, output instrStrobe, output ratio,
        output clear, input tick);
    modport divider (input srcLevel, input unsynced, input instrStrobe, input ratio,
        input clear, output tick);
endinterface
`default_nettype wire

/* File: rtl/tmz_input_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module tmz_input_divider
    import tmz_pkg::*;
#(
    parameter int PRE_W = 15
) (
    input wire logic clk,
    input wire logic reset,
    tmz_tick_if.divider bus
);
    logic prev_reg, prev_next;
    logic pend_reg, pend_next;
    logic [PRE_W-1:0] cnt_reg, cnt_next;
    logic tick_reg, tick_next;
    logic rise, fire;
    logic [PRE_W-1:0] cntInc;

    function automatic logic [PRE_W-1:0] ratioMask(input logic [3:0] r);
        ratioMask = (PRE_W'(1) << r) - PRE_W'(1);
    endfunction

    always_comb begin
        prev_next = bus.srcLevel;
        rise = bus.srcLevel & ~prev_reg;
        // synced edges wait for the next instruction cycle, capping the rate at fosc/4
        fire = bus.unsynced ? rise : (bus.instrStrobe & (pend_reg | rise)); // RL7
        pend_next = (pend_reg | (rise & ~bus.unsynced)) & ~fire;
        cntInc = cnt_reg + PRE_W'(1);
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (bus.clear) begin
            cnt_next = '0;
            pend_next = 1'b0;
        end else if (fire) begin
            cnt_next = cntInc;
            tick_next = (cntInc & ratioMask(bus.ratio)) == '0; // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_reg <= 1'b0;
            pend_reg <= 1'b0;
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            pend_reg <= pend_next;
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign bus.tick = tick_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    div_one_a: assert property (bus.unsynced && rise && bus.ratio == 4'h0 && !bus.clear |=> tick_reg) // RL8
        else $error("undivided edge gave no tick");
    sync_hold_a: assert property (!bus.unsynced && !bus.instrStrobe |=> !tick_reg) // RL7
        else $error("synced tick outside instruction cycle");
    div_eight_a: assert property (tick_reg && bus.ratio == 4'h3 && !bus.clear |-> cnt_reg[2:0] == 3'h0) // RL8
        else $error("divide by eight tick misplaced");
endmodule
`default_nettype wire

/* File: rtl/tmz_timer_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tmz_timer_regs
    import tmz_pkg::*;
#(
    parameter int PRE_W = 15
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mediumInternalOsc,
    input wire logic lowInternalOsc,
    input wire logic highInternalOsc,
    input wire logic logicCellOneOutput,
    input wire logic countPinInput,
    output logic counterOutputLevel,
    output logic countMatchPulse,
    output logic countIrq
);
    tmz_tick_if tickBus ();

    logic [7:0] ctrlMain_reg, ctrlMain_next;
    logic [7:0] clkCfg_reg, clkCfg_next;
    logic [7:0] countLow_reg, countLow_next;
    logic [7:0] countHigh_reg, countHigh_next;
    logic [7:0] highBuf_reg, highBuf_next;
    logic [7:0] period_reg, period_next;
    logic [3:0] post_reg, post_next;
    logic outLevel_reg, outLevel_next;
    logic matchPulse_reg, matchPulse_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] enable_reg, enable_next;
    logic irq_reg, irq_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic wrPend_reg, wrPend_next;
    logic [7:0] wrAddr_reg, wrAddr_next;
    logic [1:0] phase_reg, phase_next;
    logic hreadyout_reg;

    logic accept, readLowNow, writeLow, writeCtrl, running, wide, tickNow;
    logic evt, postEvent, srcLevel;
    logic [7:0] readData, statusSet, statusClr;
    logic [15:0] wideInc;

    assign running = ctrlMain_reg[RUN_BIT];
    assign wide = ctrlMain_reg[WIDE_BIT];
    assign tickNow = tickBus.tick;
    assign accept = hsel & htrans[1] & hready;
    assign readLowNow = accept & ~hwrite & (haddr[7:0] == ADDR_COUNT_LOW);
    assign writeLow = wrPend_reg & (wrAddr_reg == ADDR_COUNT_LOW);
    assign writeCtrl = wrPend_reg & ((wrAddr_reg == ADDR_CTRL_MAIN) | (wrAddr_reg == ADDR_CLK_CFG));

    // source select, all inputs already synchronous to clk
    always_comb begin
        unique case (clkCfg_reg[SRC_LSB +: 3])
            SRC_PIN: srcLevel = countPinInput;
            SRC_PIN_INV: srcLevel = ~countPinInput; // RL6
            SRC_INSTR: srcLevel = phase_reg[1]; // RL5
            SRC_HIGH_OSC: srcLevel = highInternalOsc; // RL5
            SRC_LOW_OSC: srcLevel = lowInternalOsc; // RL5
            SRC_MEDIUM_OSC: srcLevel = mediumInternalOsc; // RL5
            SRC_RESERVED: srcLevel = 1'b0; // RL5
            SRC_LOGIC_CELL: srcLevel = logicCellOneOutput; // RL6
        endcase
    end

    assign tickBus.srcLevel = srcLevel;
    assign tickBus.unsynced = clkCfg_reg[UNSYNC_BIT]; // RL7
    assign tickBus.instrStrobe = phase_reg == 2'(INSTR_DIV - 1);
    assign tickBus.ratio = clkCfg_reg[IN_DIV_LSB +: 4]; // RL8
    // a stopped timer keeps its divider cleared so nothing toggles
    assign tickBus.clear = writeLow | writeCtrl | ~running; // RL1 RL13

    tmz_input_divider #(
        .PRE_W(PRE_W)
    ) inputDivider (
        .clk(clk),
        .reset(reset),
        .bus(tickBus)
    );

    // read mux, sampled at the end of the address phase
    always_comb begin
        unique case (haddr[7:0])
            ADDR_CTRL_MAIN: readData = {ctrlMain_reg[7], 1'b0, outLevel_reg, ctrlMain_reg[4:0]}; // RL2 RL9
            ADDR_CLK_CFG: readData = clkCfg_reg;
            ADDR_COUNT_LOW: readData = countLow_reg;
            ADDR_COUNT_HIGH: readData = highBuf_reg;
            ADDR_IRQ_STATUS: readData = status_reg;
            ADDR_IRQ_ENABLE: readData = enable_reg;
            default: readData = 8'h00;
        endcase
    end

    always_comb begin
        ctrlMain_next = ctrlMain_reg;
        clkCfg_next = clkCfg_reg;
        countLow_next = countLow_reg;
        countHigh_next = countHigh_reg;
        highBuf_next = highBuf_reg;
        period_next = period_reg;
        post_next = post_reg;
        outLevel_next = outLevel_reg;
        matchPulse_next = matchPulse_reg;
        enable_next = enable_reg;
        statusSet = 8'h00;
        statusClr = 8'h00;
        phase_next = phase_reg + 2'h1;
        wrPend_next = accept & hwrite;
        wrAddr_next = haddr[7:0];
        hrdata_next = (accept & ~hwrite) ? {24'h000000, readData} : 32'h00000000;
        wideInc = {countHigh_reg, countLow_reg} + 16'h0001;
        evt = 1'b0;
        postEvent = 1'b0;

        // counting; the prescaled tick only arrives while running
        if (running && tickNow) begin // RL1
            matchPulse_next = 1'b0;
            if (wide) begin // RL3
                {countHigh_next, countLow_next} = wideInc;
                evt = {countHigh_reg, countLow_reg} == 16'hFFFF; // RL12
                // the rollover drives the same one-period pulse as an 8-bit match
                matchPulse_next = evt;
            end else if (countLow_reg == period_reg) begin // RL10
                countLow_next = 8'h00;
                period_next = highBuf_reg;
                matchPulse_next = 1'b1;
                evt = 1'b1;
            end else begin
                countLow_next = countLow_reg + 8'h01;
            end
        end

        if (evt) begin
            if (post_reg == ctrlMain_reg[OUT_DIV_LSB +: 4]) begin // RL4
                post_next = 4'h0;
                postEvent = 1'b1;
                outLevel_next = ~outLevel_reg;
            end else begin
                post_next = post_reg + 4'h1;
            end
        end
        statusSet[EVENT_FLAG_BIT] = postEvent; // RL12

        // reading the low byte freezes the true high byte for a consistent pair
        if (readLowNow && wide) begin // RL11
            highBuf_next = countHigh_reg;
        end

        if (wrPend_reg) begin
            unique case (wrAddr_reg)
                ADDR_CTRL_MAIN: ctrlMain_next = hwdata[7:0] & CTRL_MAIN_WMASK; // RL2
                ADDR_CLK_CFG: clkCfg_next = hwdata[7:0];
                ADDR_COUNT_LOW: begin
                    countLow_next = hwdata[7:0];
                    if (wide) begin
                        countHigh_next = highBuf_reg; // RL11
                    end
                end
                ADDR_COUNT_HIGH: highBuf_next = hwdata[7:0];
                ADDR_IRQ_CLEAR: statusClr = hwdata[7:0];
                ADDR_IRQ_ENABLE: enable_next = hwdata[7:0];
                default: begin
                end
            endcase
        end
        if (writeLow || writeCtrl) begin
            post_next = 4'h0; // RL13
        end
        if (!running) begin
            post_next = 4'h0; // RL1
            matchPulse_next = 1'b0;
        end

        // a new event wins over a clear in the same cycle
        status_next = (status_reg & ~statusClr) | statusSet;
        irq_next = |(status_next & enable_next);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlMain_reg <= CTRL_MAIN_RST; // RL9
            clkCfg_reg <= CLK_CFG_RST; // RL9
            countLow_reg <= COUNT_LOW_RST;
            countHigh_reg <= 8'h00;
            highBuf_reg <= HIGH_BUF_RST;
            period_reg <= PERIOD_RST;
            post_reg <= 4'h0; // RL13
            outLevel_reg <= 1'b0;
            matchPulse_reg <= 1'b0;
            status_reg <= 8'h00;
            enable_reg <= 8'h00;
            irq_reg <= 1'b0;
            hrdata_reg <= 32'h00000000;
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            phase_reg <= 2'h0;
            hreadyout_reg <= 1'b0;
        end else begin
            ctrlMain_reg <= ctrlMain_next;
            clkCfg_reg <= clkCfg_next;
            countLow_reg <= countLow_next;
            countHigh_reg <= countHigh_next;
            highBuf_reg <= highBuf_next;
            period_reg <= period_next;
            post_reg <= post_next;
            outLevel_reg <= outLevel_next;
            matchPulse_reg <= matchPulse_next;
            status_reg <= status_next;
            enable_reg <= enable_next;
            irq_reg <= irq_next;
            hrdata_reg <= hrdata_next;
            wrPend_reg <= wrPend_next;
            wrAddr_reg <= wrAddr_next;
            phase_reg <= phase_next;
            hreadyout_reg <= 1'b1;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign counterOutputLevel = outLevel_reg;
    assign countMatchPulse = matchPulse_reg;
    assign countIrq = irq_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    stop_hold_a: assert property (!running && !writeLow |=> countLow_reg == $past(countLow_reg)) // RL1
        else $error("stopped counter moved");
    out_bit_a: assert property (accept && !hwrite && haddr[7:0] == ADDR_CTRL_MAIN
        |=> hrdata[5] == $past(outLevel_reg) && hrdata[6] == 1'b0) // RL2
        else $error("control read shows wrong output bit");
    wide_roll_a: assert property (running && tickNow && wide && !wrPend_reg
        && {countHigh_reg, countLow_reg} == 16'hFFFF
        |=> countLow_reg == 8'h00 && countHigh_reg == 8'h00) // RL3
        else $error("16-bit rollover wrong");
    post_range_a: assert property (post_reg <= ctrlMain_reg[3:0]) // RL4
        else $error("output divider past its ratio");
    src_cell_a: assert property (clkCfg_reg[7:5] == SRC_LOGIC_CELL |-> srcLevel == logicCellOneOutput) // RL6
        else $error("logic cell source not routed");
    src_pin_a: assert property (clkCfg_reg[7:5] == SRC_PIN_INV |-> srcLevel == !countPinInput) // RL6
        else $error("inverted pin source not routed");
    reset_zero_a: assert property ($past(reset) |-> ctrlMain_reg == 8'h00 && clkCfg_reg == 8'h00) // RL9
        else $error("control not zero after reset");
    match_eight_a: assert property (running && tickNow && !wide && !wrPend_reg
        && countLow_reg == period_reg
        |=> countLow_reg == 8'h00 && matchPulse_reg && period_reg == $past(highBuf_reg)) // RL10
        else $error("8-bit match handling wrong");
    latch_high_a: assert property (readLowNow && wide && !wrPend_reg
        |=> highBuf_reg == $past(countHigh_reg)) // RL11
        else $error("low read did not latch high byte");
    flag_set_a: assert property (postEvent
        |=> status_reg[EVENT_FLAG_BIT] && (countIrq || !enable_reg[EVENT_FLAG_BIT])) // RL12
        else $error("event flag not set");
    wr_clear_a: assert property (wrPend_reg && (writeLow || writeCtrl) |=> post_reg == 4'h0) // RL13
        else $error("write did not clear output divider");
endmodule
`default_nettype wire

/* File: test/tmz_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import tmz_pkg::*;
;
    localparam int LIMIT = 60000;

    typedef struct packed {
        logic [2:0] src;
        logic unsync;
        logic [3:0] inDiv;
        logic [3:0] outDiv;
        logic [7:0] period;
        int unsigned cycles;
    } tmz_row_t;

    // each row: clock setup beside the clk count between two output toggles
    tmz_row_t rows [11] = '{
        '{SRC_INSTR, 1'h0, 4'h0, 4'h0, 8'h02, 12},
        '{SRC_INSTR, 1'h0, 4'h1, 4'h3, 8'h04, 160},
        '{SRC_INSTR, 1'h0, 4'h3, 4'hF, 8'h01, 1024},
        '{SRC_INSTR, 1'h0, 4'h0, 4'hD, 8'h01, 112},
        '{SRC_MEDIUM_OSC, 1'h1, 4'h0, 4'h0, 8'h01, 20},
        '{SRC_LOW_OSC, 1'h1, 4'h0, 4'h0, 8'h01, 28},
        '{SRC_HIGH_OSC, 1'h1, 4'h0, 4'h0, 8'h01, 4},
        '{SRC_HIGH_OSC, 1'h0, 4'h0, 4'h0, 8'h01, 8},
        '{SRC_LOGIC_CELL, 1'h1, 4'h0, 4'h0, 8'h01, 36},
        '{SRC_PIN, 1'h1, 4'h0, 4'h0, 8'h01, 16},
        '{SRC_PIN_INV, 1'h1, 4'h0, 4'h0, 8'h01, 16}
    };

    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic mediumOsc, lowOsc, highOsc, cellOut, pinIn;
    logic outLevel, matchPulse, irq;
    int cyc;
    int mismatches;
    int checks_done;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    tmz_timer_regs #(.PRE_W(15)) dut_u (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mediumInternalOsc(mediumOsc), .lowInternalOsc(lowOsc),
        .highInternalOsc(highOsc), .logicCellOneOutput(cellOut),
        .countPinInput(pinIn), .counterOutputLevel(outLevel),
        .countMatchPulse(matchPulse), .countIrq(irq)
    );

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // source levels with distinct periods so a wrong source select shows up
    always @(posedge clk) begin
        cyc <= cyc + 1;
        mediumOsc <= (cyc % 10) < 5;
        lowOsc <= (cyc % 14) < 7;
        highOsc <= cyc[0];
        cellOut <= (cyc % 18) < 9;
        pinIn <= (cyc % 8) < 4;
        if (cyc == LIMIT) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic expect_eq(input logic [31:0] got, input logic [31:0] want, input string what);
        checks_done++;
        if (got !== want) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        hwrite <= 1'h1;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, v};
        do @(posedge clk); while (hready !== 1'h1);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        hwrite <= 1'h0;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        do @(posedge clk); while (hready !== 1'h1);
        v = hrdata;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] want);
        logic [31:0] v;
        bus_read(a, v);
        expect_eq(v, {24'h000000, want}, "register read");
    endtask

    // returns clk edges until the output level changes, bounded by limit
    task automatic wait_level(input int limit, output int n);
        logic start;
        start = outLevel;
        n = 0;
        while (outLevel === start && n < limit) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        int n;
        logic [31:0] d;
        reset = 1'h1;
        hsel = 1'h0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        cyc = 0;
        {mediumOsc, lowOsc, highOsc, cellOut, pinIn} = 5'h00;
        mismatches = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd_check(ADDR_CTRL_MAIN, 8'h00);
        rd_check(ADDR_CLK_CFG, 8'h00);
        rd_check(ADDR_COUNT_LOW, 8'h00);
        rd_check(ADDR_COUNT_HIGH, 8'hFF);
        rd_check(ADDR_IRQ_STATUS, 8'h00);
        rd_check(ADDR_IRQ_ENABLE, 8'h00);
        bus_write(ADDR_CTRL_MAIN, 8'h7F);
        rd_check(ADDR_CTRL_MAIN, 8'h1F);
        bus_write(ADDR_CLK_CFG, 8'hA5);
        rd_check(ADDR_CLK_CFG, 8'hA5);
        bus_write(ADDR_IRQ_CLEAR, 8'h01);
        rd_check(ADDR_IRQ_CLEAR, 8'h00);
        bus_write(8'h1C, 8'hFF);
        rd_check(8'h1C, 8'h00);
        foreach (rows[i]) begin
            bus_write(ADDR_COUNT_HIGH, rows[i].period);
            bus_write(ADDR_CLK_CFG, {SRC_INSTR, 5'h00});
            bus_write(ADDR_CTRL_MAIN, 8'h80);
            // a match is needed before the new period takes effect
            wait_level(2100, n);
            bus_write(ADDR_CLK_CFG, {rows[i].src, rows[i].unsync, rows[i].inDiv});
            bus_write(ADDR_CTRL_MAIN, {4'h8, rows[i].outDiv});
            wait_level(2100, n);
            wait_level(2100, n);
            expect_eq(n, rows[i].cycles, "toggle interval");
        end
        bus_write(ADDR_CLK_CFG, {SRC_INSTR, 5'h00});
        bus_write(ADDR_CTRL_MAIN, 8'h80);
        bus_write(ADDR_COUNT_HIGH, 8'hFF);
        wait_level(100, n);
        bus_write(ADDR_IRQ_CLEAR, 8'h01);
        rd_check(ADDR_IRQ_STATUS, 8'h00);
        wait_level(1200, n);
        repeat (4) @(posedge clk);
        rd_check(ADDR_IRQ_STATUS, 8'h01);
        expect_eq(irq, 1'h0, "masked irq");
        bus_write(ADDR_IRQ_ENABLE, 8'h01);
        rd_check(ADDR_IRQ_ENABLE, 8'h01);
        expect_eq(irq, 1'h1, "enabled irq");
        bus_write(ADDR_IRQ_CLEAR, 8'h01);
        rd_check(ADDR_IRQ_STATUS, 8'h00);
        expect_eq(irq, 1'h0, "cleared irq");
        bus_write(ADDR_CTRL_MAIN, 8'h00);
        bus_read(ADDR_COUNT_LOW, d);
        repeat (50) @(posedge clk);
        rd_check(ADDR_COUNT_LOW, d[7:0]);
        bus_read(ADDR_CTRL_MAIN, d);
        expect_eq(d[5], outLevel, "output level bit");
        bus_write(ADDR_CTRL_MAIN, 8'h10);
        bus_write(ADDR_COUNT_HIGH, 8'h12);
        bus_write(ADDR_COUNT_LOW, 8'h34);
        rd_check(ADDR_COUNT_LOW, 8'h34);
        rd_check(ADDR_COUNT_HIGH, 8'h12);
        bus_write(ADDR_COUNT_HIGH, 8'hFF);
        bus_write(ADDR_COUNT_LOW, 8'hFD);
        bus_write(ADDR_CTRL_MAIN, 8'h90);
        n = 0;
        while (matchPulse !== 1'h1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        expect_eq(n < 20, 1'h1, "wide rollover");
        bus_read(ADDR_COUNT_LOW, d);
        rd_check(ADDR_COUNT_HIGH, 8'h00);
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        expect_eq(irq, 1'h0, "irq after reset");
        rd_check(ADDR_CTRL_MAIN, 8'h00);
        rd_check(ADDR_COUNT_HIGH, 8'hFF);
        rd_check(ADDR_COUNT_LOW, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
